// File: rtl/rhps_host_port.sv
// Host parallel access port with composite blank and sync handling
`timescale 1ns/1ps
module rhps_host_port #(
  parameter int PIPE_DEPTH = rhps_pkg::PIPE_DEPTH_DEF,
  parameter int CH_W = rhps_pkg::CH_W_DEF
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic ce_n_i,
  input wire logic read_write_i,
  input wire logic [rhps_pkg::CMD_W-1:0] command_select_i,
  input wire logic [rhps_pkg::DATA_W-1:0] host_databus_i,
  output logic [rhps_pkg::DATA_W-1:0] host_databus_o,
  output logic host_databus_oe_n_o,
  input wire logic [1:0] bus_mode_i,
  output logic wr_valid_o,
  output logic [rhps_pkg::CMD_W-1:0] wr_cmd_o,
  output logic [rhps_pkg::DATA_W-1:0] wr_data_o,
  output logic rd_req_o,
  output logic [rhps_pkg::CMD_W-1:0] rd_cmd_o,
  input wire logic [rhps_pkg::DATA_W-1:0] rd_data_i,
  input wire logic pixel_load_strobe_i,
  input wire logic blank_n_i,
  input wire logic sync_n_i,
  input wire logic [rhps_pkg::PSEL_W-1:0] palette_priority_select_i,
  input wire logic [3*CH_W-1:0] pixel_i,
  input wire logic sync_decode_enable_i,
  output logic [CH_W-1:0] red_level_o,
  output logic [CH_W-1:0] green_level_o,
  output logic [CH_W-1:0] blue_level_o,
  output logic [rhps_pkg::PSEL_W-1:0] palette_priority_select_o,
  output logic video_blank_o,
  output logic green_current_out_sync_o,
  output logic delayed_sync_out_n_o
);
  localparam int PIX_W = 3 * CH_W;
  localparam int VP_W = PIX_W + rhps_pkg::PSEL_W + 3;
  localparam logic [rhps_pkg::HP_W-1:0] HP_RST = {1'b1, {(rhps_pkg::HP_W-1){1'b0}}};
  // Strobe low, blank_n and sync_n idle high
  localparam logic [VP_W-1:0] VP_RST = {3'h3, {(VP_W-3){1'b0}}};

  if (CH_W < 1 || CH_W > rhps_pkg::BYTE_W) begin : g_bad_ch
    $error("CH_W must lie between one and eight");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Pins come from the host and pixel domains; two flops before any use, except bus_mode_i and sync_decode_enable_i, which are used directly
  logic [rhps_pkg::HP_W-1:0] hp_meta_r;
  logic [rhps_pkg::HP_W-1:0] hp_sync_r;
  logic [VP_W-1:0] vp_meta_r;
  logic [VP_W-1:0] vp_sync_r;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hp_meta_r <= HP_RST;
      hp_sync_r <= HP_RST;
      vp_meta_r <= VP_RST;
      vp_sync_r <= VP_RST;
    end else begin
      hp_meta_r <= {ce_n_i, read_write_i, command_select_i, host_databus_i};
      hp_sync_r <= hp_meta_r;
      // Strobe, controls and pixel share one flop row so they stay aligned
      vp_meta_r <= {pixel_load_strobe_i, blank_n_i, sync_n_i,
                    palette_priority_select_i, pixel_i};
      vp_sync_r <= vp_meta_r;
    end
  end

  logic ce_n_s;
  logic rw_s;
  logic [rhps_pkg::CMD_W-1:0] cmd_s;
  logic [rhps_pkg::DATA_W-1:0] data_s;
  assign ce_n_s = hp_sync_r[rhps_pkg::HP_CE_BIT];
  assign rw_s = hp_sync_r[rhps_pkg::HP_RW_BIT];
  assign cmd_s = hp_sync_r[rhps_pkg::HP_CMD_LSB +: rhps_pkg::CMD_W];
  assign data_s = hp_sync_r[rhps_pkg::HP_DATA_LSB +: rhps_pkg::DATA_W];

  // ****************************************
  // Host access sequencer
  // ****************************************
  rhps_pkg::rhps_acc_state_t acc_r, acc_nxt;
  rhps_pkg::rhps_bus_mode_t mode;
  logic ce_prev_r, ce_prev_nxt;
  logic [rhps_pkg::CMD_W-1:0] cmd_r, cmd_nxt;
  logic [rhps_pkg::DATA_W-1:0] hold_r, hold_nxt;
  logic [rhps_pkg::BYTE_W-1:0] lo_byte_r, lo_byte_nxt;
  logic byte_hi_r, byte_hi_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic [rhps_pkg::DATA_W-1:0] rd_word_r, rd_word_nxt;
  logic [rhps_pkg::DATA_W-1:0] bus_out_r, bus_out_nxt;
  logic oe_n_r, oe_n_nxt;
  logic wr_valid_r, wr_valid_nxt;
  logic [rhps_pkg::CMD_W-1:0] wr_cmd_r, wr_cmd_nxt;
  logic [rhps_pkg::DATA_W-1:0] wr_data_r, wr_data_nxt;
  logic rd_req_r, rd_req_nxt;
  logic ce_fall;
  logic ce_rise;

  assign ce_fall = ce_prev_r && !ce_n_s;
  assign ce_rise = !ce_prev_r && ce_n_s;

  always_comb begin
    unique case (bus_mode_i)
      2'h1: mode = rhps_pkg::RHPS_MODE_BYTE82;
      2'h2: mode = rhps_pkg::RHPS_MODE_BYTE8;
      default: mode = rhps_pkg::RHPS_MODE_PAR10;
    endcase
  end

  always_comb begin
    acc_nxt = acc_r;
    ce_prev_nxt = ce_n_s;
    cmd_nxt = cmd_r;
    hold_nxt = hold_r;
    lo_byte_nxt = lo_byte_r;
    byte_hi_nxt = byte_hi_r;
    rd_pend_nxt = 1'b0;
    rd_word_nxt = rd_word_r;
    bus_out_nxt = bus_out_r;
    wr_valid_nxt = 1'b0;
    wr_cmd_nxt = wr_cmd_r;
    wr_data_nxt = wr_data_r;
    rd_req_nxt = 1'b0;
    // Hold data while selected; value just before the rising edge is used
    if (!ce_n_s) begin
      hold_nxt = data_s;
    end
    unique case (acc_r)
      rhps_pkg::RHPS_ACC_IDLE: begin
        if (ce_fall) begin
          cmd_nxt = cmd_s;
          acc_nxt = rw_s ? rhps_pkg::RHPS_ACC_READ : rhps_pkg::RHPS_ACC_WRITE;
          // High byte of an 8+2 read comes from the word already fetched
          if (rw_s && !(mode == rhps_pkg::RHPS_MODE_BYTE82 && byte_hi_r)) begin
            rd_req_nxt = 1'b1;
            rd_pend_nxt = 1'b1;
          end
        end
      end
      rhps_pkg::RHPS_ACC_READ: begin
        if (rd_pend_r) begin
          rd_word_nxt = rd_data_i;
        end
        if (ce_rise) begin
          acc_nxt = rhps_pkg::RHPS_ACC_IDLE;
          byte_hi_nxt = (mode == rhps_pkg::RHPS_MODE_BYTE82) && !byte_hi_r;
        end
      end
      rhps_pkg::RHPS_ACC_WRITE: begin
        if (ce_rise) begin
          acc_nxt = rhps_pkg::RHPS_ACC_IDLE;
          wr_cmd_nxt = cmd_r;
          unique case (mode)
            rhps_pkg::RHPS_MODE_PAR10: begin
              wr_valid_nxt = 1'b1;
              wr_data_nxt = hold_r;
            end
            rhps_pkg::RHPS_MODE_BYTE8: begin
              wr_valid_nxt = 1'b1;
              wr_data_nxt = {{rhps_pkg::HI_W{1'b0}}, hold_r[rhps_pkg::BYTE_W-1:0]};
            end
            rhps_pkg::RHPS_MODE_BYTE82: begin
              if (byte_hi_r) begin
                wr_valid_nxt = 1'b1;
                wr_data_nxt = {hold_r[rhps_pkg::HI_W-1:0], lo_byte_r};
              end else begin
                lo_byte_nxt = hold_r[rhps_pkg::BYTE_W-1:0];
              end
              byte_hi_nxt = !byte_hi_r;
            end
          endcase
        end
      end
      default: begin
        acc_nxt = rhps_pkg::RHPS_ACC_IDLE;
      end
    endcase
    if (mode != rhps_pkg::RHPS_MODE_BYTE82) begin
      byte_hi_nxt = 1'b0;
    end
    // Read data lane arrangement per bus width
    unique case (mode)
      rhps_pkg::RHPS_MODE_BYTE82: begin
        bus_out_nxt = byte_hi_r ?
          {{rhps_pkg::BYTE_W{1'b0}}, rd_word_nxt[rhps_pkg::DATA_W-1:rhps_pkg::BYTE_W]} :
          {{rhps_pkg::HI_W{1'b0}}, rd_word_nxt[rhps_pkg::BYTE_W-1:0]};
      end
      rhps_pkg::RHPS_MODE_BYTE8: begin
        bus_out_nxt = {{rhps_pkg::HI_W{1'b0}}, rd_word_nxt[rhps_pkg::BYTE_W-1:0]};
      end
      default: begin
        bus_out_nxt = rd_word_nxt;
      end
    endcase
    // Release lags chip-select by the synchroniser depth plus the output register
    oe_n_nxt = !(acc_nxt == rhps_pkg::RHPS_ACC_READ);
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_r <= rhps_pkg::RHPS_ACC_IDLE;
      ce_prev_r <= 1'b1;
      cmd_r <= rhps_pkg::CMD_RST;
      hold_r <= rhps_pkg::DATA_RST;
      lo_byte_r <= '0;
      byte_hi_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_word_r <= rhps_pkg::DATA_RST;
      bus_out_r <= rhps_pkg::DATA_RST;
      oe_n_r <= 1'b1;
      wr_valid_r <= 1'b0;
      wr_cmd_r <= rhps_pkg::CMD_RST;
      wr_data_r <= rhps_pkg::DATA_RST;
      rd_req_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      ce_prev_r <= ce_prev_nxt;
      cmd_r <= cmd_nxt;
      hold_r <= hold_nxt;
      lo_byte_r <= lo_byte_nxt;
      byte_hi_r <= byte_hi_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_word_r <= rd_word_nxt;
      bus_out_r <= bus_out_nxt;
      oe_n_r <= oe_n_nxt;
      wr_valid_r <= wr_valid_nxt;
      wr_cmd_r <= wr_cmd_nxt;
      wr_data_r <= wr_data_nxt;
      rd_req_r <= rd_req_nxt;
    end
  end

  assign host_databus_o = bus_out_r;
  assign host_databus_oe_n_o = oe_n_r;
  assign wr_valid_o = wr_valid_r;
  assign wr_cmd_o = wr_cmd_r;
  assign wr_data_o = wr_data_r;
  assign rd_req_o = rd_req_r;
  assign rd_cmd_o = cmd_r;

  // ****************************************
  // Video capture on pixel load strobe
  // ****************************************
  logic strobe_s;
  logic strobe_prev_r, strobe_prev_nxt;
  logic [PIX_W-1:0] cap_pix_r, cap_pix_nxt;
  logic [rhps_pkg::PSEL_W-1:0] cap_psel_r, cap_psel_nxt;
  logic cap_blank_r, cap_blank_nxt;
  logic cap_sync_r, cap_sync_nxt;
  logic cap_gsync_r, cap_gsync_nxt;
  logic blank_s;
  logic sync_s;

  assign strobe_s = vp_sync_r[VP_W-1];
  assign blank_s = !vp_sync_r[VP_W-2];
  assign sync_s = !vp_sync_r[VP_W-3];

  always_comb begin
    strobe_prev_nxt = strobe_s;
    cap_pix_nxt = cap_pix_r;
    cap_psel_nxt = cap_psel_r;
    cap_blank_nxt = cap_blank_r;
    cap_sync_nxt = cap_sync_r;
    cap_gsync_nxt = cap_gsync_r;
    if (strobe_s && !strobe_prev_r) begin
      cap_psel_nxt = vp_sync_r[PIX_W +: rhps_pkg::PSEL_W];
      cap_blank_nxt = blank_s;
      cap_sync_nxt = sync_s;
      // Blank overrides pixel data; green sync is valid only inside blank, delayed sync is not gated
      cap_pix_nxt = blank_s ? {3{rhps_pkg::BLANK_LEVEL[CH_W-1:0]}} : vp_sync_r[PIX_W-1:0];
      cap_gsync_nxt = sync_decode_enable_i && sync_s && blank_s;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_prev_r <= 1'b0;
      cap_pix_r <= '0;
      cap_psel_r <= '0;
      cap_blank_r <= 1'b1;
      cap_sync_r <= 1'b0;
      cap_gsync_r <= 1'b0;
    end else begin
      strobe_prev_r <= strobe_prev_nxt;
      cap_pix_r <= cap_pix_nxt;
      cap_psel_r <= cap_psel_nxt;
      cap_blank_r <= cap_blank_nxt;
      cap_sync_r <= cap_sync_nxt;
      cap_gsync_r <= cap_gsync_nxt;
    end
  end

  // ****************************************
  // Output pipeline
  // ****************************************
  rhps_video_if #(.PIX_W(PIX_W)) cap_bus ();
  rhps_video_if #(.PIX_W(PIX_W)) out_bus ();

  assign cap_bus.pixel = cap_pix_r;
  assign cap_bus.psel = cap_psel_r;
  assign cap_bus.blank = cap_blank_r;
  assign cap_bus.sync = cap_sync_r;
  assign cap_bus.green_sync = cap_gsync_r;

  rhps_video_pipe #(
    .PIPE_DEPTH(PIPE_DEPTH),
    .PIX_W(PIX_W)
  ) u_pipe (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .in_bus(cap_bus),
    .out_bus(out_bus)
  );

  assign {red_level_o, green_level_o, blue_level_o} = out_bus.pixel;
  assign palette_priority_select_o = out_bus.psel;
  assign video_blank_o = out_bus.blank;
  assign green_current_out_sync_o = out_bus.green_sync;
  assign delayed_sync_out_n_o = !out_bus.sync;
endmodule

// File: rtl/rhps_pkg.sv
// Shared constants and types for the host port and sync block
package rhps_pkg;

  // ****************************************
  // Host databus
  // ****************************************
  localparam int DATA_W = 10;
  localparam int BYTE_W = 8;
  localparam int HI_W = DATA_W - BYTE_W;
  localparam int CMD_W = 2;
  localparam int PSEL_W = 2;

  // ****************************************
  // Pin synchroniser layout, host side
  // ****************************************
  localparam int HP_DATA_LSB = 0;
  localparam int HP_CMD_LSB = HP_DATA_LSB + DATA_W;
  localparam int HP_RW_BIT = HP_CMD_LSB + CMD_W;
  localparam int HP_CE_BIT = HP_RW_BIT + 1;
  localparam int HP_W = HP_CE_BIT + 1;

  // ****************************************
  // Video defaults and reset values
  // ****************************************
  localparam int CH_W_DEF = 8;
  localparam int PIPE_DEPTH_DEF = 4;
  localparam logic [BYTE_W-1:0] BLANK_LEVEL = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 10'h000;
  localparam logic [CMD_W-1:0] CMD_RST = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RHPS_MODE_PAR10,
    RHPS_MODE_BYTE82,
    RHPS_MODE_BYTE8
  } rhps_bus_mode_t;

  typedef enum logic [1:0] {
    RHPS_ACC_IDLE,
    RHPS_ACC_READ,
    RHPS_ACC_WRITE
  } rhps_acc_state_t;

endpackage

// File: rtl/rhps_video_if.sv
// Video sample bundle passed between capture and pipeline
`timescale 1ns/1ps
interface rhps_video_if #(
  parameter int PIX_W = 24
);
  logic [PIX_W-1:0] pixel;
  logic [rhps_pkg::PSEL_W-1:0] psel;
  logic blank;
  logic sync;
  logic green_sync;

  modport src (
    output pixel,
    output psel,
    output blank,
    output sync,
    output green_sync
  );
  modport dst (
    input pixel,
    input psel,
    input blank,
    input sync,
    input green_sync
  );
endinterface

// File: rtl/rhps_video_pipe.sv
// Fixed-depth pipeline shared by pixel, blank and sync paths
`timescale 1ns/1ps
module rhps_video_pipe #(
  parameter int PIPE_DEPTH = rhps_pkg::PIPE_DEPTH_DEF,
  parameter int PIX_W = 24
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  rhps_video_if.dst in_bus,
  rhps_video_if.src out_bus
);
  localparam int W = PIX_W + rhps_pkg::PSEL_W + 3;
  // Blank asserted, sync idle after reset
  localparam logic [W-1:0] STAGE_RST = {{(W-3){1'b0}}, 3'h4};

  if (PIPE_DEPTH < 1) begin : g_bad_depth
    $error("PIPE_DEPTH must be at least one");
  end

  logic [W-1:0] stage_r [PIPE_DEPTH];
  logic [W-1:0] stage_nxt [PIPE_DEPTH];

  // ****************************************
  // Shift every clock; one depth for all fields keeps them aligned
  // ****************************************
  always_comb begin
    stage_nxt[0] = {in_bus.pixel, in_bus.psel, in_bus.blank, in_bus.sync, in_bus.green_sync};
    for (int i = 1; i < PIPE_DEPTH; i++) begin
      stage_nxt[i] = stage_r[i-1];
    end
  end

  for (genvar g = 0; g < PIPE_DEPTH; g++) begin : g_stage
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        stage_r[g] <= STAGE_RST;
      end else begin
        stage_r[g] <= stage_nxt[g];
      end
    end
  end

  assign {out_bus.pixel, out_bus.psel, out_bus.blank, out_bus.sync, out_bus.green_sync} =
    stage_r[PIPE_DEPTH-1];
endmodule

// File: tb/rhps_host_port_asserts.sv
// Port assertions for the host port and sync block
`timescale 1ns/1ps
module rhps_host_port_asserts #(
  parameter int CH_W = rhps_pkg::CH_W_DEF
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic ce_n_i,
  input wire logic read_write_i,
  input wire logic [1:0] bus_mode_i,
  input wire logic [rhps_pkg::DATA_W-1:0] rd_data_i,
  input wire logic [rhps_pkg::DATA_W-1:0] host_databus_o,
  input wire logic host_databus_oe_n_o,
  input wire logic wr_valid_o,
  input wire logic rd_req_o,
  input wire logic [CH_W-1:0] red_level_o,
  input wire logic [CH_W-1:0] green_level_o,
  input wire logic [CH_W-1:0] blue_level_o,
  input wire logic video_blank_o,
  input wire logic green_current_out_sync_o,
  input wire logic delayed_sync_out_n_o
);
  // ****************************************
  // Checks
  // ****************************************
  // Pins pass two flops, so every host figure lags the pin by three edges
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_OE_READ_ONLY: assert property (!host_databus_oe_n_o |->
    !$past(ce_n_i, 3) && $past(read_write_i, 3)) else $error("bus driven outside read");
  AST_OE_IDLE: assert property (ce_n_i [*4] |-> host_databus_oe_n_o)
    else $error("bus not released while idle");
  AST_WR_PULSE: assert property (wr_valid_o |=> !wr_valid_o)
    else $error("write pulse too long");
  AST_WR_AT_RISE: assert property (wr_valid_o |->
    $past(ce_n_i, 3) && !$past(ce_n_i, 4) && !$past(read_write_i, 4))
    else $error("write word not at select rise");
  AST_RD_AT_FALL: assert property (rd_req_o |->
    !$past(ce_n_i, 3) && $past(ce_n_i, 4) && $past(read_write_i, 3))
    else $error("read fetch not at select fall");
  AST_RD_DATA: assert property (rd_req_o && bus_mode_i == 2'h0 |->
    ##2 (host_databus_o == $past(rd_data_i) && !host_databus_oe_n_o))
    else $error("read word not on bus");
  AST_BLANK_LEVEL: assert property (video_blank_o |->
    {red_level_o, green_level_o, blue_level_o} == '0) else $error("blank not at level");
  AST_GREEN_SYNC: assert property (green_current_out_sync_o |->
    video_blank_o && !delayed_sync_out_n_o) else $error("green sync misaligned");
endmodule
bind rhps_host_port rhps_host_port_asserts #(.CH_W(CH_W)) u_chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_n_i(ce_n_i),
  .read_write_i(read_write_i), .bus_mode_i(bus_mode_i), .rd_data_i(rd_data_i),
  .host_databus_o(host_databus_o), .host_databus_oe_n_o(host_databus_oe_n_o),
  .wr_valid_o(wr_valid_o), .rd_req_o(rd_req_o), .red_level_o(red_level_o),
  .green_level_o(green_level_o), .blue_level_o(blue_level_o),
  .video_blank_o(video_blank_o), .green_current_out_sync_o(green_current_out_sync_o),
  .delayed_sync_out_n_o(delayed_sync_out_n_o));

// File: tb/rhps_host_model.sv
// Host processor model driving the parallel access port
`timescale 1ns/1ps
module rhps_host_model (
  input wire logic clk_i,
  input wire logic oe_n_i,
  input wire logic [9:0] dev_data_i,
  output logic ce_n_o,
  output logic rw_o,
  output logic [1:0] cmd_o,
  output logic [9:0] bus_o
);
  logic drv;
  logic [9:0] dat;
  initial begin
    ce_n_o = 1'b1;
    rw_o = 1'b0;
    cmd_o = 2'h0;
    drv = 1'b0;
    dat = 10'h000;
  end
  // Released bus shows the inverse, so stale data never passes
  assign bus_o = !oe_n_i ? dev_data_i : (drv ? dat : ~dat);
  task automatic acc(input logic rw, input logic [1:0] cmd, input logic [9:0] d,
                     output logic [9:0] q);
    @(negedge clk_i);
    rw_o = rw;
    cmd_o = cmd;
    dat = d;
    drv = !rw;
    @(negedge clk_i);
    ce_n_o = 1'b0;
    repeat (3) @(negedge clk_i);
    cmd_o = ~cmd;
    repeat (3) @(negedge clk_i);
    q = bus_o;
    ce_n_o = 1'b1;
    // Data held past the synchroniser lag of the rise
    repeat (3) @(negedge clk_i);
    drv = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
endmodule

// File: tb/tb_rhps_host_port.sv
// Self-checking bench for the host port and sync block
`timescale 1ns/1ps
module tb_rhps_host_port;
  logic sys_clk_i, resetn_i, ce_n, rw, oe_n, wv, rreq, strobe, bn, sn, en, vb, gs, ds_n;
  logic [1:0] cmd, mode, wcmd, rcmd, psel, pselo, wc_seen;
  logic [9:0] bus, dout, wdata, rdata, wr_seen, q, q2;
  logic [23:0] pix;
  logic [7:0] red, grn, blu;
  int failures, total_checks, wr_cnt, lat;
  assign rdata = 10'h2C3 ^ {8'h00, rcmd};
  rhps_host_port #(.PIPE_DEPTH(3), .CH_W(8)) dut_u (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .ce_n_i(ce_n), .read_write_i(rw), .command_select_i(cmd),
    .host_databus_i(bus), .host_databus_o(dout), .host_databus_oe_n_o(oe_n),
    .bus_mode_i(mode), .wr_valid_o(wv), .wr_cmd_o(wcmd), .wr_data_o(wdata),
    .rd_req_o(rreq), .rd_cmd_o(rcmd), .rd_data_i(rdata), .pixel_load_strobe_i(strobe),
    .blank_n_i(bn), .sync_n_i(sn), .palette_priority_select_i(psel), .pixel_i(pix),
    .sync_decode_enable_i(en), .red_level_o(red), .green_level_o(grn),
    .blue_level_o(blu), .palette_priority_select_o(pselo), .video_blank_o(vb),
    .green_current_out_sync_o(gs), .delayed_sync_out_n_o(ds_n));
  rhps_host_model u_host (.clk_i(sys_clk_i), .oe_n_i(oe_n), .dev_data_i(dout),
    .ce_n_o(ce_n), .rw_o(rw), .cmd_o(cmd), .bus_o(bus));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (wv === 1'b1) begin
      wr_cnt++;
      wr_seen = wdata;
      wc_seen = wcmd;
    end
  end
  // ****************************************
  // Common tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    @(negedge sys_clk_i) resetn_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    check("reset outputs", {oe_n, wv, rreq, vb, gs, ds_n, red, grn, blu}, 30'h25000000);
  endtask
  task automatic t_write();
    logic [9:0] d;
    int w0;
    for (int m = 0; m < 5; m++) begin
      mode = (m == 4) ? 2'h3 : 2'h0;
      d = 10'h2A5 ^ {5{m[1:0]}};
      w0 = wr_cnt;
      u_host.acc(1'b0, m[1:0], d, q);
      check("write count", wr_cnt - w0, 1);
      check("write data", wr_seen, d);
      check("write cmd", wc_seen, m[1:0]);
    end
  endtask
  task automatic t_read();
    int w0;
    mode = 2'h0;
    for (int c = 0; c < 4; c++) begin
      w0 = wr_cnt;
      u_host.acc(1'b1, c[1:0], 10'h000, q);
      check("read data", q, 10'h2C3 ^ c[9:0]);
      check("read no write", wr_cnt - w0, 0);
      check("read release", oe_n, 1'b1);
    end
  endtask
  task automatic t_byte();
    int w0;
    mode = 2'h1;
    w0 = wr_cnt;
    u_host.acc(1'b0, 2'h0, 10'h3A7, q);
    check("low byte no word", wr_cnt - w0, 0);
    u_host.acc(1'b0, 2'h1, 10'h302, q);
    check("byte word", wr_seen, 10'h2A7);
    u_host.acc(1'b1, 2'h2, 10'h000, q);
    u_host.acc(1'b1, 2'h2, 10'h000, q2);
    check("read low byte", q[7:0], 8'hC1);
    check("read high bits", q2[1:0], 2'h2);
    mode = 2'h2;
    u_host.acc(1'b0, 2'h3, 10'h3FF, q);
    check("eight bit word", wr_seen, 10'h0FF);
  endtask
  task automatic vid(input logic b, input logic s, input logic e, input logic [23:0] p);
    logic [28:0] exp;
    int n;
    exp = {b ? p : 24'h0, p[1:0], !b, e & !s & !b, s};
    @(negedge sys_clk_i);
    bn = b;
    sn = s;
    en = e;
    pix = p;
    psel = p[1:0];
    @(negedge sys_clk_i) strobe = 1'b1;
    n = 0;
    while ({red, grn, blu, pselo, vb, gs, ds_n} !== exp && n < 20) begin
      @(negedge sys_clk_i);
      n++;
      if (n == 2) strobe = 1'b0;
    end
    check("video outputs", {red, grn, blu, pselo, vb, gs, ds_n}, exp);
    check("video delay", n, lat);
    repeat (2) @(negedge sys_clk_i);
    strobe = 1'b0;
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic t_video();
    // Two pin flops, capture flop, then three pipe stages, seen at the falling edge
    lat = 6;
    vid(1'b1, 1'b1, 1'b1, 24'h123456);
    vid(1'b0, 1'b0, 1'b1, 24'hFEDCBA);
    vid(1'b0, 1'b0, 1'b0, 24'hFEDCB9);
    vid(1'b1, 1'b1, 1'b1, 24'hFFFFFF);
  endtask
  initial begin
    failures = 0;
    total_checks = 0;
    wr_cnt = 0;
    resetn_i = 1'b0;
    mode = 2'h0;
    strobe = 1'b0;
    bn = 1'b1;
    sn = 1'b1;
    en = 1'b0;
    psel = 2'h0;
    pix = 24'h000000;
    t_reset();
    t_write();
    t_read();
    t_byte();
    t_video();
    t_reset();
    stop_test();
  end
  // Whole run is a few hundred cycles
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule
